// ==== pkg/ppgtnf_pkg.sv ====
// How it works
// - Mode field 011 selects pulse mode; clock-select field picks the counter tick.
// - Idle and initial pulse level equals the output-level bit.
// - Run bit starts counting; mode, overflow enable and level bit lock while running.
// - Toggle match drives the pulse to the inverse of the output-level bit.
// - Period match restores the output-level bit's level and pulses the interrupt request.
// - One-shot repeat setting clears the run bit at the period match.
// - Continuous repeat setting clears the counter at the period match and runs on.
// - Whenever the run bit falls the pulse returns to the output-level bit.
// - Repeat bit stays writable while running, judged at each period match.
// - Double-buffered running writes take effect only at the period match.
// - Unbuffered running writes act at once; a passed value makes the counter wrap.
// - Low-byte writes go to an 8-bit stage; high-byte write moves both bytes.
// - Compare reads return the buffered last-written value.
// - Writes while stopped load both buffer and active compare value.
// - Filter output changes after three consecutive identical samples.
// - Any nonzero filter setting runs the filter regardless of the run bit.
// - Filter field writes are ignored while the run bit is 1.
// - Filter setting 01, 10, 11 samples every 2, 4, 256 clocks.
// - Slow mode: setting 11 samples at low clock over two; 01 and 10 block input.
package ppgtnf_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 11;

  localparam logic [ADDR_W-1:0] OFS_MODE    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PER_LO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PER_HI  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TOG_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TOG_HI  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h1C;

  localparam int MODE_OP_LSB = 0;
  localparam int MODE_CK_LSB = 3;
  localparam logic [2:0] OP_PPG    = 3'h3;
  localparam logic [5:0] MODE_RST  = 6'h00;

  localparam int CTRL_RUN   = 0;
  localparam int CTRL_REP   = 1;
  localparam int CTRL_LVL   = 2;
  localparam int CTRL_OVFE  = 3;
  localparam int CTRL_DBUF  = 4;
  localparam int CTRL_NF_LSB = 5;
  localparam logic [6:0] CTRL_RST = 7'h00;

  localparam int STAT_PULSE = 0;
  localparam int STAT_FILT  = 1;

  localparam logic [1:0] NF_OFF = 2'h0;
  localparam logic [1:0] NF_2   = 2'h1;
  localparam logic [1:0] NF_4   = 2'h2;
  localparam logic [1:0] NF_256 = 2'h3;
  localparam logic [3:0] NF_LG_2   = 4'h1;
  localparam logic [3:0] NF_LG_4   = 4'h2;
  localparam logic [3:0] NF_LG_256 = 4'h8;
  localparam logic [3:0] NF_LG_LF  = 4'h1;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
    logic              psel;
    logic              penable;
  } ppgtnf_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } ppgtnf_apb_rsp_t;

  // Divider exponent for each clock-select code, gear clock
  function automatic logic [3:0] ck_lg_fast(input logic [2:0] sel);
    case (sel)
      3'h0: ck_lg_fast = 4'hB;
      3'h1: ck_lg_fast = 4'hA;
      3'h2: ck_lg_fast = 4'h8;
      3'h3: ck_lg_fast = 4'h6;
      3'h4: ck_lg_fast = 4'h4;
      3'h5: ck_lg_fast = 4'h2;
      3'h6: ck_lg_fast = 4'h1;
      default: ck_lg_fast = 4'h0;
    endcase
  endfunction : ck_lg_fast

  // Exponent on the low-frequency clock; codes without one give no tick
  function automatic logic [3:0] ck_lg_slow(input logic [2:0] sel);
    case (sel)
      3'h0: ck_lg_slow = 4'h4;
      3'h1: ck_lg_slow = 4'h3;
      default: ck_lg_slow = 4'h2;
    endcase
  endfunction : ck_lg_slow

endpackage : ppgtnf_pkg

// ==== src/ppgtnf_top.sv ====
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ppgtnf_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire ppgtnf_pkg::ppgtnf_apb_req_t apb_req,
  output ppgtnf_pkg::ppgtnf_apb_rsp_t      apb_rsp,
  input  wire logic                        slow_mode,
  input  wire logic                        low_freq_clock_tick,
  input  wire logic                        timer_input_pin,
  output logic                             pulse_output_pin,
  output logic                             timer_interrupt_request,
  output logic                             filtered_input
);

  // Shared prescaler decode: true once every 2**lg counts
  function automatic logic div_tick(input logic [ppgtnf_pkg::PRE_W-1:0] d,
                                    input logic [3:0] lg);
    logic [ppgtnf_pkg::PRE_W:0] m;
    m = (12'h001 << lg) - 12'h001;
    div_tick = (d & m[ppgtnf_pkg::PRE_W-1:0]) == m[ppgtnf_pkg::PRE_W-1:0];
  endfunction : div_tick

  logic [ppgtnf_pkg::PRE_W-1:0] pre_q;
  logic [3:0]                   lf_q;
  logic [5:0]                   mode_q;
  logic                         run_q;
  logic                         rep_q;
  logic                         lvl_q;
  logic                         ovfe_q;
  logic                         dbuf_q;
  logic [1:0]                   nf_q;
  logic [7:0]                   stage_q;
  logic [15:0]                  per_buf_q;
  logic [15:0]                  per_act_q;
  logic [15:0]                  tog_buf_q;
  logic [15:0]                  tog_act_q;
  logic [15:0]                  cnt_q;
  logic                         pulse_q;
  logic                         irq_q;
  logic [1:0]                   samp_q;
  logic                         filt_q;
  logic [31:0]                  prdata_q;

  // Bus decode
  wire [7:0]  addr      = apb_req.paddr;
  wire [31:0] wdata     = apb_req.pwdata;
  wire        setup     = apb_req.psel & ~apb_req.penable;
  wire        access    = apb_req.psel & apb_req.penable;
  wire        wr        = access & apb_req.pwrite;
  wire        hit_mode  = addr == ppgtnf_pkg::OFS_MODE;
  wire        hit_ctrl  = addr == ppgtnf_pkg::OFS_CTRL;
  wire        hit_plo   = addr == ppgtnf_pkg::OFS_PER_LO;
  wire        hit_phi   = addr == ppgtnf_pkg::OFS_PER_HI;
  wire        hit_tlo   = addr == ppgtnf_pkg::OFS_TOG_LO;
  wire        hit_thi   = addr == ppgtnf_pkg::OFS_TOG_HI;
  wire        hit_cnt   = addr == ppgtnf_pkg::OFS_COUNT;
  wire        hit_stat  = addr == ppgtnf_pkg::OFS_STATUS;
  wire        addr_ok   = hit_mode | hit_ctrl | hit_plo | hit_phi | hit_tlo | hit_thi
                          | hit_cnt | hit_stat;
  wire        wr_mode   = wr & hit_mode;
  wire        wr_ctrl   = wr & hit_ctrl;
  wire        wr_lo     = wr & (hit_plo | hit_tlo);
  wire        wr_phi    = wr & hit_phi;
  wire        wr_thi    = wr & hit_thi;
  wire [15:0] wr_val    = {wdata[7:0], stage_q};
  wire        sw_run    = wdata[ppgtnf_pkg::CTRL_RUN];

  // Source tick selection
  wire [2:0]  op_sel    = mode_q[ppgtnf_pkg::MODE_OP_LSB +: 3];
  wire [2:0]  ck_sel    = mode_q[ppgtnf_pkg::MODE_CK_LSB +: 3];
  wire        running   = run_q & (op_sel == ppgtnf_pkg::OP_PPG);
  wire        slow_ck_ok = (ck_sel == 3'h0) | (ck_sel == 3'h1) | (ck_sel == 3'h7);
  localparam int PRE_WL = ppgtnf_pkg::PRE_W;
  wire [PRE_WL-1:0] lf_ext = {{(PRE_WL-4){1'b0}}, lf_q};
  wire        fast_tick = div_tick(pre_q, ppgtnf_pkg::ck_lg_fast(ck_sel));
  wire        slow_tick = slow_ck_ok & low_freq_clock_tick
                          & div_tick(lf_ext, ppgtnf_pkg::ck_lg_slow(ck_sel));
  wire        src_tick  = slow_mode ? slow_tick : fast_tick;

  // Compare events
  wire        per_match = cnt_q == per_act_q;
  wire        tog_match = cnt_q == tog_act_q;
  wire        ev_per    = running & src_tick & per_match;
  wire        ev_tog    = running & src_tick & tog_match & ~per_match;
  wire        hold      = run_q & dbuf_q;

  // Noise filter sample timing
  wire        nf_on     = nf_q != ppgtnf_pkg::NF_OFF;
  wire        nf_block  = slow_mode & (nf_q == ppgtnf_pkg::NF_2 | nf_q == ppgtnf_pkg::NF_4);
  wire [3:0]  nf_lg     = (nf_q == ppgtnf_pkg::NF_2) ? ppgtnf_pkg::NF_LG_2 :
                          (nf_q == ppgtnf_pkg::NF_4) ? ppgtnf_pkg::NF_LG_4 :
                                                       ppgtnf_pkg::NF_LG_256;
  wire        samp_tick = slow_mode
                          ? (low_freq_clock_tick & div_tick(lf_ext, ppgtnf_pkg::NF_LG_LF))
                          : div_tick(pre_q, nf_lg);
  wire        three_eq  = (timer_input_pin == samp_q[0]) & (samp_q[0] == samp_q[1]);

  // Free-running dividers
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= '0;
      lf_q  <= '0;
    end else begin
      pre_q <= pre_q + 11'h001;
      if (low_freq_clock_tick) begin
        lf_q <= lf_q + 4'h1;
      end
    end
  end

  // Mode and control bits
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= ppgtnf_pkg::MODE_RST;
      {nf_q, dbuf_q, ovfe_q, lvl_q, rep_q, run_q} <= ppgtnf_pkg::CTRL_RST;
    end else begin
      if (wr_mode && !run_q) begin
        mode_q <= wdata[5:0];
      end
      if (wr_ctrl) begin
        rep_q  <= wdata[ppgtnf_pkg::CTRL_REP];
        dbuf_q <= wdata[ppgtnf_pkg::CTRL_DBUF];
        if (!run_q) begin
          lvl_q  <= wdata[ppgtnf_pkg::CTRL_LVL];
          ovfe_q <= wdata[ppgtnf_pkg::CTRL_OVFE];
          nf_q   <= wdata[ppgtnf_pkg::CTRL_NF_LSB +: 2];
        end
      end
      // Software start beats a same-cycle auto-stop
      if (wr_ctrl) begin
        run_q <= sw_run;
      end else if (ev_per && rep_q) begin
        run_q <= 1'b0;
      end
    end
  end

  // Staging byte and compare registers
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_q   <= '0;
      per_buf_q <= '0;
      per_act_q <= '0;
      tog_buf_q <= '0;
      tog_act_q <= '0;
    end else begin
      if (wr_lo) begin
        stage_q <= wdata[7:0];
      end
      if (ev_per && dbuf_q) begin
        per_act_q <= per_buf_q;
        tog_act_q <= tog_buf_q;
      end
      if (wr_phi) begin
        per_buf_q <= wr_val;
        if (!hold) begin
          per_act_q <= wr_val;
        end
      end
      if (wr_thi) begin
        tog_buf_q <= wr_val;
        if (!hold) begin
          tog_act_q <= wr_val;
        end
      end
    end
  end

  // Counter; a passed compare value is reached only after wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= ppgtnf_pkg::CNT_ZERO;
    end else if (!running) begin
      cnt_q <= ppgtnf_pkg::CNT_ZERO;
    end else if (src_tick) begin
      cnt_q <= per_match ? ppgtnf_pkg::CNT_ZERO : cnt_q + 16'h0001;
    end
  end

  // Pulse output and interrupt request
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      irq_q <= ev_per;
      if (!running || ev_per) begin
        pulse_q <= lvl_q;
      end else if (ev_tog) begin
        pulse_q <= ~lvl_q;
      end
    end
  end

  // Noise canceller, runs whatever the run bit says
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_q <= '0;
      filt_q <= 1'b0;
    end else if (!nf_on) begin
      samp_q <= {2{timer_input_pin}};
      filt_q <= timer_input_pin;
    end else if (nf_block) begin
      filt_q <= 1'b0;
    end else if (samp_tick) begin
      samp_q <= {samp_q[0], timer_input_pin};
      if (three_eq) begin
        filt_q <= timer_input_pin;
      end
    end
  end

  // Read data captured in setup so the access phase needs no wait
  wire [31:0] rd_mux =
    hit_mode ? {26'h0, mode_q} :
    hit_ctrl ? {25'h0, nf_q, dbuf_q, ovfe_q, lvl_q, rep_q, run_q} :
    hit_plo  ? {24'h0, per_buf_q[7:0]} :
    hit_phi  ? {24'h0, per_buf_q[15:8]} :
    hit_tlo  ? {24'h0, tog_buf_q[7:0]} :
    hit_thi  ? {24'h0, tog_buf_q[15:8]} :
    hit_cnt  ? {16'h0, cnt_q} :
    hit_stat ? {30'h0, filt_q, pulse_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign apb_rsp.prdata          = prdata_q;
  assign apb_rsp.pready          = 1'b1;
  assign apb_rsp.pslverr         = access & ~addr_ok;
  assign pulse_output_pin        = pulse_q;
  assign timer_interrupt_request = irq_q;
  assign filtered_input          = filt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_period;
    ev_per & ~rep_q;
  endsequence

  sequence s_restart;
    ##1 (cnt_q == ppgtnf_pkg::CNT_ZERO);
  endsequence

  AST_IDLE_LEVEL: assert property ($fell(run_q) |=> pulse_q == $past(lvl_q))
    else $error("pulse not back at level after stop");

  AST_MODE_LOCK: assert property (run_q && wr_mode |=> $stable(mode_q))
    else $error("mode changed while running");

  AST_TOGGLE: assert property (ev_tog |=> pulse_q == ~$past(lvl_q))
    else $error("toggle match did not invert pulse");

  AST_PERIOD: assert property (ev_per |=> pulse_q == $past(lvl_q) && irq_q)
    else $error("period match wrong level or no request");

  AST_ONESHOT: assert property (ev_per && rep_q && !wr_ctrl |=> !run_q ##1 pulse_q == $past(lvl_q))
    else $error("one-shot did not stop");

  AST_CONT: assert property (s_period |-> s_restart)
    else $error("counter not cleared in continuous run");

  AST_DBUF_HOLD: assert property (hold && wr_phi && !ev_per |=> $stable(per_act_q))
    else $error("buffered write took effect early");

  AST_DIRECT: assert property (wr_phi && !hold |=> per_act_q == $past(wr_val))
    else $error("direct compare write lost");

  AST_NF_LOCK: assert property (run_q && wr_ctrl |=> $stable(nf_q))
    else $error("filter field changed while running");

  AST_FILTER: assert property (nf_on && !nf_block && samp_tick && !three_eq
                               |=> $stable(filt_q))
    else $error("filter changed without three equal samples");

  AST_IRQ_PULSE: assert property (irq_q |=> !irq_q)
    else $error("request held without match");

endmodule : ppgtnf_top
`default_nettype wire

// ==== tb/ppgtnf_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppgtnf_far_side (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic drive_lvl,
  input  wire logic pulse_in,
  output var  logic pin_out,
  output var  int   rise_cnt
);
  logic pulse_q;

  // Push-pull source, registered: the pin lags the command by one clock
  always @(posedge clk) begin
    pin_out <= rst ? 1'h0 : drive_lvl;
    pulse_q <= pulse_in;
    if (rst)
      rise_cnt <= 0;
    else if (pulse_in && !pulse_q)
      rise_cnt <= rise_cnt + 1;
  end
endmodule : ppgtnf_far_side
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                        clk;
  logic                        rst;
  ppgtnf_pkg::ppgtnf_apb_req_t req;
  ppgtnf_pkg::ppgtnf_apb_rsp_t rsp;
  logic                        slow;
  logic                        lf_tick = 1'h0;
  logic [2:0]                  lfc = 3'h0;
  logic                        drv;
  logic                        pin;
  logic                        pulse;
  logic                        irq;
  logic                        filt;
  logic [31:0]                 rd;
  logic                        err;
  int                          bad_count;
  int                          n_checks;
  int                          rises;
  int                          r0;
  int                          per;
  int                          tog;
  int                          iv;
  int                          n;
  int                          off;
  int                          cyc = 0;
  int                          t0;

  ppgtnf_top i_ppgtnf_top (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .slow_mode(slow), .low_freq_clock_tick(lf_tick), .timer_input_pin(pin),
    .pulse_output_pin(pulse), .timer_interrupt_request(irq), .filtered_input(filt));
  ppgtnf_far_side i_ppgtnf_far_side (.clk(clk), .rst(rst), .drive_lvl(drv),
    .pulse_in(pulse), .pin_out(pin), .rise_cnt(rises));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Low-frequency clock stand-in: one tick every eight clocks
  always @(posedge clk) begin
    lfc     <= lfc + 3'h1;
    lf_tick <= (lfc == 3'h7);
    cyc     <= cyc + 1;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string nm, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_cnt

  // Wait states allowed: holds the access until pready is seen; watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel    <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'h1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    chk_val(nm, exp, rd);
  endtask : rdchk

  // Low byte first so both halves land together
  task automatic setcmp(input logic [7:0] a, input logic [15:0] v);
    apb(1'h1, a, {24'h0, v[7:0]});
    apb(1'h1, a + 8'h4, {24'h0, v[15:8]});
  endtask : setcmp

  function automatic logic [31:0] ctrl(input logic run, input logic rep, input logic lvl,
                                       input logic db, input logic [1:0] nf);
    ctrl = {25'h0, nf, db, 1'h0, lvl, rep, run};
  endfunction : ctrl

  // Cycles up to the next request, and how many of them the pulse was inverted
  task automatic wirq(input logic lvl);
    n   = 0;
    off = 0;
    do begin
      @(posedge clk);
      n++;
      if (pulse !== lvl)
        off++;
    end while (irq !== 1'h1 && n < 3000);
  endtask : wirq

  task automatic wfilt(input logic v, input int lim);
    int t;
    t = 0;
    while (filt !== v && t < lim) begin
      @(posedge clk);
      t++;
    end
  endtask : wfilt

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    req       = '0;
    slow      = 1'h0;
    drv       = 1'h0;
    rst       = 1'h1;
    bad_count = 0;
    n_checks  = 0;
    void'($urandom(32'h20A88AC4));
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rdchk(ppgtnf_pkg::OFS_MODE, 32'h0, "mode reset");
    rdchk(ppgtnf_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    apb(1'h0, 8'h20, 32'h0);
    chk_val("unmapped err", 32'h1, {31'h0, err});
    chk_val("unmapped data", 32'h0, rd);
    $display("test reset done");
    for (int lv = 0; lv < 2; lv++) begin
      per = 10 + $urandom % 50;
      tog = 1 + $urandom % (per - 1);
      apb(1'h1, ppgtnf_pkg::OFS_MODE, (lv != 0) ? 32'h3B : 32'h33);
      setcmp(ppgtnf_pkg::OFS_PER_LO, per[15:0]);
      setcmp(ppgtnf_pkg::OFS_TOG_LO, tog[15:0]);
      rdchk(ppgtnf_pkg::OFS_PER_LO, {24'h0, per[7:0]}, "stopped write");
      apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h1, lv[0], 1'h0, 2'h0));
      repeat (2) @(posedge clk);
      chk_val("idle level", lv, pulse);
      apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h1, 1'h1, lv[0], 1'h0, 2'h0));
      wirq(lv[0]);
      chk_cnt("one-shot width", (per - tog) * (2 - lv), off);
      repeat (3) @(posedge clk);
      chk_val("one-shot rest", lv, pulse);
      rdchk(ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h1, lv[0], 1'h0, 2'h0), "auto stop");
    end
    $display("test one-shot done");
    apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h1, 1'h0, 1'h1, 1'h0, 2'h0));
    wirq(1'h1);
    r0 = rises;
    wirq(1'h1);
    chk_cnt("period", per + 1, n);
    chk_cnt("width", per - tog, off);
    chk_cnt("pulses", 1, rises - r0);
    apb(1'h1, ppgtnf_pkg::OFS_MODE, 32'h0);
    rdchk(ppgtnf_pkg::OFS_MODE, 32'h3B, "mode locked");
    apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h1, 1'h0, 1'h0, 1'h0, 2'h1));
    rdchk(ppgtnf_pkg::OFS_CTRL, ctrl(1'h1, 1'h0, 1'h1, 1'h0, 2'h0), "ctrl locked");
    apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h1, 1'h1, 1'h1, 1'h0, 2'h0));
    // A match on the write edge itself still runs on, so allow a whole period
    repeat (per + 4) @(posedge clk);
    rdchk(ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h1, 1'h1, 1'h0, 2'h0), "late one-shot");
    chk_val("late one-shot level", 32'h1, pulse);
    $display("test continuous done");
    for (int db = 1; db >= 0; db--) begin
      setcmp(ppgtnf_pkg::OFS_PER_LO, 16'h0028);
      setcmp(ppgtnf_pkg::OFS_TOG_LO, 16'h000A);
      per = 50 + $urandom % 40;
      apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h1, 1'h0, 1'h0, db[0], 2'h0));
      wirq(1'h0);
      t0 = cyc;
      setcmp(ppgtnf_pkg::OFS_PER_LO, per[15:0]);
      rdchk(ppgtnf_pkg::OFS_PER_LO, {24'h0, per[7:0]}, "read buffer");
      wirq(1'h0);
      chk_cnt("period after write", (db == 1) ? 41 : per + 1, cyc - t0);
      if (db == 1) begin
        wirq(1'h0);
        chk_cnt("buffered period", per + 1, n);
      end
      repeat (15) @(posedge clk);
      chk_val("pulse on", 32'h1, pulse);
      apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h0, 1'h0, db[0], 2'h0));
      repeat (2) @(posedge clk);
      chk_val("soft stop level", 32'h0, pulse);
    end
    $display("test double buffer done");
    for (int c = 1; c < 4; c++) begin
      iv = (c == 1) ? 2 : (c == 2) ? 4 : 256;
      apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h0, 1'h0, 1'h0, c[1:0]));
      repeat (4 * iv) @(posedge clk);
      drv <= 1'h1;
      repeat (2 * iv) @(posedge clk);
      chk_val("filter hold", 32'h0, filt);
      wfilt(1'h1, 4 * iv + 8);
      chk_val("filter change", 32'h1, filt);
      drv <= 1'h0;
      wfilt(1'h0, 4 * iv + 8);
    end
    apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h0, 1'h0, 1'h0, 2'h1));
    drv <= 1'h1;
    @(posedge clk);
    drv <= 1'h0;
    repeat (12) @(posedge clk);
    chk_val("glitch removed", 32'h0, filt);
    drv <= 1'h1;
    wfilt(1'h1, 20);
    slow <= 1'h1;
    repeat (12) @(posedge clk);
    chk_val("slow blocked", 32'h0, filt);
    apb(1'h1, ppgtnf_pkg::OFS_CTRL, ctrl(1'h0, 1'h0, 1'h0, 1'h0, 2'h3));
    wfilt(1'h1, 200);
    chk_val("slow sampled", 32'h1, filt);
    slow <= 1'h0;
    $display("test filter done");
    conclude();
  end
endmodule : tb
`default_nettype wire
